// >>> design/shr_pkg.sv
/*
 * Package for the switch hot reset sequencer: register offsets, field
 * positions, reset values, timing counts and shared types.
 * Assumes a single 20 MHz core clock and a plain register port.
 */
package shr_pkg;

	localparam int CLK_PERIOD_NS = 50;
	localparam int RST_OUT_MIN_NS = 250;
	// least time rounds up
	localparam int RST_OUT_CYCLES = (RST_OUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MSG_CYCLES = 4;

	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_GPIO_MODE = 4'h4;
	localparam logic [3:0] OFS_NTB_CTRL = 4'h8;
	localparam logic [3:0] OFS_NTB_STATUS = 4'hC;

	// control register: secondary bus reset, bridge mode and reset output select bits
	localparam int CTRL_SBR_UP = 0;
	localparam int CTRL_SBR_B = 1;
	localparam int CTRL_SBR_C = 2;
	localparam int CTRL_NT_MODE = 3;
	localparam int CTRL_ROS = 4;

	// gpio mode register: alternate function enables
	localparam int GPIO_ALT_B = 0;
	localparam int GPIO_ALT_C = 1;

	// bridge side control register
	localparam int NTB_RESET_ACTION_ENABLE = 0;
	localparam int NTB_RA = 1;
	localparam int NTB_PROPAGATE_EXTERNAL_FUND_RESET_INT = 2;
	localparam int NTB_PROPAGATE_EXTERNAL_FUND_RESET_EXT = 3;
	localparam int NTB_OPPOSITE_SIDE_MODE = 4;

	// bridge side status register
	localparam int STS_OPPOSITE_RESET_DETECTED = 0;
	localparam int STS_OPPOSITE_FUND_RESET_DETECTED = 1;
	localparam int STS_BUSY = 2;

	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] NTB_RESET = 8'h00;
	localparam logic [7:0] BUS_UNMAPPED = 8'h00;

	typedef enum logic [1:0]
	{
		SQ_IDLE = 2'b00,
		SQ_MSG = 2'b01,
		SQ_HOLD = 2'b10
	} shr_state_t;

	typedef struct packed
	{
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} shr_bus_t;

	typedef struct packed
	{
		logic ts1_hot_reset;
		logic dl_down;
		logic ds_ts1_hot_reset;
	} shr_link_t;

endpackage

// >>> design/shr_top.sv
/*
 * Hot reset sequencer for a three port switch with non-transparent bridge
 * support. Drives downstream reset pins, port hot-reset messages, scoped
 * logic resets and transaction hold-off.
 * Assumes link events arrive synchronous to core_clk, pins are synchronised.
 */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - hot reset drives affected downstream reset output low at least 250 ns
// - port B reset is gpio bit 0 alternate, port C is gpio bit 1
// - global hot reset returns gpio to input, reset outputs undriven
// - upstream TS1 hot reset starts whole-device hot reset
// - upstream data link down starts whole-device hot reset
// - hot reset goes only downstream; downstream TS1 ignored
// - whole-device hot reset resets core logic, not PLL, SerDes, SMBus
// - no hot reset ever requests serial EEPROM reload
// - sticky and lock-protected fields survive whole-device hot reset
// - global hot reset: downstream ports send message before own reset
// - downstream-ports reset resets downstream logic, keeps sticky fields
// - downstream-ports reset leaves upstream config except status
// - port secondary bus reset: send message then reset physical layer
// - local port hot reset leaves all config registers except status
// - reset action enable applies selected action on opposite side reset
// - internal fundamental reset in bridge mode resets everything
// - internal fundamental reset sets opposite side mode not ready
// - bridge reset input in bridge mode starts external fundamental reset
// - propagate bit on either side makes it a whole-device reset
// - otherwise reset only external side layers and non-locked registers
// - external fundamental reset sets opposite reset detected flags
// - external reset asserts port C reset 250 ns when output select chooses it
module shr_top
	import shr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire shr_bus_t bus,
	output logic [7:0] rdata,
	input wire shr_link_t link,
	input wire logic bridge_reset_in_n,
	output logic port_b_reset_out_n,
	output logic port_b_reset_oe,
	output logic port_c_reset_out_n,
	output logic port_c_reset_oe,
	output logic [2:0] hot_reset_msg,
	output logic core_reset,
	output logic [2:0] port_phy_reset,
	output logic ext_side_reset,
	output logic [2:0] hold_off,
	output logic ext_side_not_ready,
	output logic opposite_side_mode,
	output logic eeprom_reload
);

	logic [7:0] ctrl_r;
	logic [1:0] gpio_alt_r;
	logic [7:0] ntb_ctrl_r;
	logic [1:0] sts_r;
	logic [1:0] brst_sync_r;
	logic brst_prev_r;
	logic ext_fund;
	logic wr_ctrl;
	logic wr_sts;
	logic glob_start;
	logic [2:0] port_start;
	shr_state_t st_r [3];
	logic [2:0] cnt_r [3];
	logic glob_r;
	logic [2:0] busy;
	logic [3:0] pc_ext_cnt_r;
	logic ext_prop;
	logic ra_hold_r;

	assign wr_ctrl = bus.wr && bus.addr == OFS_CTRL;
	assign wr_sts = bus.wr && bus.addr == OFS_NTB_STATUS;
	// downstream TS1 is not a trigger on purpose
	assign glob_start = link.ts1_hot_reset | link.dl_down;

	// bridge reset pin is asynchronous to core_clk
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			brst_sync_r <= 2'h3;
		else
			brst_sync_r <= {brst_sync_r[0], bridge_reset_in_n};
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			brst_prev_r <= 1'b1;
		else
			brst_prev_r <= brst_sync_r[1];
	end

	assign ext_fund = ctrl_r[CTRL_NT_MODE] && brst_prev_r && !brst_sync_r[1];
	// either side's propagate bit turns the pin into a whole-device reset
	assign ext_prop = ext_fund
		&& (ntb_ctrl_r[NTB_PROPAGATE_EXTERNAL_FUND_RESET_INT] || ntb_ctrl_r[NTB_PROPAGATE_EXTERNAL_FUND_RESET_EXT]);

	// control register; secondary bus reset bits self-clear after starting
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			ctrl_r <= CTRL_RESET;
		else if (wr_ctrl)
			ctrl_r <= bus.wdata;
		else
			ctrl_r[2:0] <= 3'h0;
	end

	// gpio modes are not sticky: a global hot reset returns them to inputs
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			gpio_alt_r <= 2'h0;
		else if (glob_start)
			gpio_alt_r <= 2'h0;
		else if (bus.wr && bus.addr == OFS_GPIO_MODE)
			gpio_alt_r <= bus.wdata[1:0];
	end

	// bridge side control is lock-protected, survives hot reset and external reset
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ntb_ctrl_r <= NTB_RESET;
			ntb_ctrl_r[NTB_OPPOSITE_SIDE_MODE] <= 1'b1;
		end
		else if (bus.wr && bus.addr == OFS_NTB_CTRL)
			ntb_ctrl_r <= bus.wdata;
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			sts_r <= 2'h0;
		else if (ext_fund)
			sts_r <= 2'h3;
		else if (wr_sts)
			sts_r <= sts_r & ~bus.wdata[1:0];
	end

	// reset action sticks until software rewrites bridge control; a one-cycle
	// flag would let traffic in before the root has reconfigured the bridge
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			ra_hold_r <= 1'b0;
		else if (ext_fund && ntb_ctrl_r[NTB_RESET_ACTION_ENABLE] && ntb_ctrl_r[NTB_RA])
			ra_hold_r <= 1'b1;
		else if (bus.wr && bus.addr == OFS_NTB_CTRL)
			ra_hold_r <= 1'b0;
	end

	// not-ready follows opposite side mode or reset action on an external reset
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			ext_side_not_ready <= 1'b1;
		else if (ext_fund && ntb_ctrl_r[NTB_RESET_ACTION_ENABLE] && ntb_ctrl_r[NTB_RA])
			ext_side_not_ready <= 1'b1;
		else
			ext_side_not_ready <= ntb_ctrl_r[NTB_OPPOSITE_SIDE_MODE] || ra_hold_r;
	end

	// whole-device fundamental reset on propagate, else external side only
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			ext_side_reset <= 1'b1;
		else
			ext_side_reset <= ext_fund && !ntb_ctrl_r[NTB_PROPAGATE_EXTERNAL_FUND_RESET_INT]
				&& !ntb_ctrl_r[NTB_PROPAGATE_EXTERNAL_FUND_RESET_EXT];
	end

	assign port_start[0] = glob_start | ext_prop;
	assign port_start[1] = glob_start | ctrl_r[CTRL_SBR_UP] | ctrl_r[CTRL_SBR_B];
	assign port_start[2] = glob_start | ctrl_r[CTRL_SBR_UP] | ctrl_r[CTRL_SBR_C];

	// per-port sequencer: hot reset message first on ports B and C, then logic and pin reset
	genvar p;
	generate
		for (p = 0; p < 3; p++)
		begin : g_port
			always_ff @(posedge core_clk or negedge rst_b)
			begin
				if (!rst_b)
				begin
					st_r[p] <= SQ_IDLE;
					cnt_r[p] <= 3'h0;
				end
				else
				begin
					unique case (st_r[p])
						SQ_IDLE:
							if (port_start[p])
							begin
								st_r[p] <= (p == 0) ? SQ_HOLD : SQ_MSG;
								cnt_r[p] <= 3'h0;
							end
						SQ_MSG:
							if (cnt_r[p] == 3'(MSG_CYCLES - 1))
							begin
								st_r[p] <= SQ_HOLD;
								cnt_r[p] <= 3'h0;
							end
							else
								cnt_r[p] <= cnt_r[p] + 3'h1;
						SQ_HOLD:
							if (cnt_r[p] == 3'(RST_OUT_CYCLES - 1))
								st_r[p] <= SQ_IDLE;
							else
								cnt_r[p] <= cnt_r[p] + 3'h1;
						default:
							st_r[p] <= SQ_IDLE;
					endcase
				end
			end
			assign busy[p] = st_r[p] != SQ_IDLE;
		end
	endgenerate

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			glob_r <= 1'b0;
		else if (glob_start || ext_prop)
			glob_r <= 1'b1;
		else if (!busy[0] && !busy[1] && !busy[2])
			glob_r <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			pc_ext_cnt_r <= 4'h0;
		else if (ext_fund && ctrl_r[CTRL_ROS])
			pc_ext_cnt_r <= 4'(RST_OUT_CYCLES);
		else if (pc_ext_cnt_r != 4'h0)
			pc_ext_cnt_r <= pc_ext_cnt_r - 4'h1;
	end

	// outputs, all registered
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			port_b_reset_out_n <= 1'b0;
			port_b_reset_oe <= 1'b0;
			port_c_reset_out_n <= 1'b0;
			port_c_reset_oe <= 1'b0;
			hot_reset_msg <= 3'h0;
			core_reset <= 1'b1;
			port_phy_reset <= 3'h7;
			hold_off <= 3'h7;
			opposite_side_mode <= 1'b1;
			eeprom_reload <= 1'b0;
		end
		else
		begin
			port_b_reset_out_n <= !(busy[1] && st_r[1] == SQ_HOLD);
			port_b_reset_oe <= gpio_alt_r[GPIO_ALT_B] && !glob_start;
			port_c_reset_out_n <= !((busy[2] && st_r[2] == SQ_HOLD)
				|| pc_ext_cnt_r != 4'h0);
			port_c_reset_oe <= gpio_alt_r[GPIO_ALT_C] && !glob_start;
			for (int i = 0; i < 3; i++)
			begin
				hot_reset_msg[i] <= st_r[i] == SQ_MSG && i != 0;
				port_phy_reset[i] <= st_r[i] == SQ_HOLD;
			end
			// only the whole-device reset touches the core, sticky state excluded
			core_reset <= glob_r && st_r[0] == SQ_HOLD;
			hold_off <= busy;
			opposite_side_mode <= ntb_ctrl_r[NTB_OPPOSITE_SIDE_MODE];
			eeprom_reload <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			rdata <= 8'h00;
		else if (bus.rd)
		begin
			unique case (bus.addr)
				OFS_CTRL: rdata <= ctrl_r;
				OFS_GPIO_MODE: rdata <= {6'h00, gpio_alt_r};
				OFS_NTB_CTRL: rdata <= ntb_ctrl_r;
				OFS_NTB_STATUS: rdata <= {5'h00, |busy, sts_r};
				default: rdata <= BUS_UNMAPPED;
			endcase
		end
		else
			rdata <= 8'h00;
	end

	a_pin_low_time: assert property (@(posedge core_clk) disable iff (!rst_b)
		$fell(port_b_reset_out_n) |-> !port_b_reset_out_n [*5])
		else $error("port b reset shorter than 250 ns");
	a_msg_before_rst: assert property (@(posedge core_clk) disable iff (!rst_b)
		$rose(port_phy_reset[1]) |-> $past(hot_reset_msg[1]))
		else $error("port b reset without prior message");
	a_glob_gpio_off: assert property (@(posedge core_clk) disable iff (!rst_b)
		glob_start |=> !port_b_reset_oe && !port_c_reset_oe)
		else $error("gpio still driven after global hot reset");
	a_ts1_starts: assert property (@(posedge core_clk) disable iff (!rst_b)
		link.ts1_hot_reset && st_r[0] == SQ_IDLE |-> ##2 core_reset)
		else $error("ts1 hot reset did not reset core");
	a_dl_down_starts: assert property (@(posedge core_clk) disable iff (!rst_b)
		link.dl_down && st_r[0] == SQ_IDLE |=> st_r[0] == SQ_HOLD)
		else $error("dl down did not start reset");
	a_ds_ts1_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
		link.ds_ts1_hot_reset && !glob_start && !ext_prop && !busy[0] |=> !busy[0])
		else $error("downstream ts1 reset the device");
	a_no_reload: assert property (@(posedge core_clk) disable iff (!rst_b)
		!eeprom_reload)
		else $error("hot reset requested eeprom reload");
	a_opposite_reset_detected_set: assert property (@(posedge core_clk) disable iff (!rst_b)
		ext_fund |=> sts_r == 2'h3)
		else $error("opposite reset flags not set");
	a_hold_busy: assert property (@(posedge core_clk) disable iff (!rst_b)
		busy[2] |=> hold_off[2])
		else $error("transactions not held off");
	a_oe_alt_only: assert property (@(posedge core_clk) disable iff (!rst_b)
		port_c_reset_oe |-> $past(gpio_alt_r[GPIO_ALT_C]))
		else $error("port c pin driven outside alternate function");
	a_prop_whole: assert property (@(posedge core_clk) disable iff (!rst_b)
		ext_prop && st_r[0] == SQ_IDLE |-> ##2 core_reset)
		else $error("propagated external reset did not reset core");
	a_ra_not_ready: assert property (@(posedge core_clk) disable iff (!rst_b)
		ext_fund && ntb_ctrl_r[NTB_RESET_ACTION_ENABLE] && ntb_ctrl_r[NTB_RA] |=> ext_side_not_ready)
		else $error("reset action did not make the side not ready");

	c_global: cover property (@(posedge core_clk) disable iff (!rst_b) glob_start ##1 busy[2]);
	c_local_b: cover property (@(posedge core_clk) disable iff (!rst_b)
		ctrl_r[CTRL_SBR_B] ##[1:8] port_phy_reset[1]);
	c_ext_fund: cover property (@(posedge core_clk) disable iff (!rst_b) ext_fund);
	c_ext_pin: cover property (@(posedge core_clk) disable iff (!rst_b)
		ext_fund && ctrl_r[CTRL_ROS]);
	c_prop: cover property (@(posedge core_clk) disable iff (!rst_b) ext_prop);

endmodule

`default_nettype wire

// >>> test/shr_link_model.sv
/*
 * Downstream link partners of ports B and C: pin levels and pulse widths.
 * Assumes the switch outputs change only on core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module shr_link_model
(
	input wire logic core_clk,
	input wire logic [1:0] out_n,
	input wire logic [1:0] oe,
	input wire logic [1:0] msg,
	output logic [1:0] pin,
	output logic [1:0][7:0] msg_len,
	output logic [1:0][7:0] rst_len,
	output logic [1:0] msg_first
);
	logic [1:0][7:0] run_m = '0;
	logic [1:0][7:0] run_r = '0;
	logic [1:0] seen = '0;
	// board pull-down: an undriven pin reads as reset
	assign pin = oe & out_n;
	for (genvar i = 0; i < 2; i++)
	begin : g_port
		always @(posedge core_clk)
		begin
			run_m[i] <= msg[i] ? run_m[i] + 8'h01 : 8'h00;
			if (!msg[i] && run_m[i] != 8'h00)
			begin
				msg_len[i] <= run_m[i];
				seen[i] <= 1'b1;
			end
			run_r[i] <= (oe[i] && !out_n[i]) ? run_r[i] + 8'h01 : 8'h00;
			if (!(oe[i] && !out_n[i]) && run_r[i] != 8'h00)
			begin
				rst_len[i] <= run_r[i];
				msg_first[i] <= seen[i];
				seen[i] <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// >>> test/shr_top_tb.sv
/*
 * Self-checking bench for the hot reset sequencer.
 * Assumes the register map and timing counts of the package.
 */
`timescale 1ns/1ps
`default_nettype none
module shr_top_tb;
	import shr_pkg::*;
	logic core_clk, rst_b, bridge_reset_in_n;
	shr_bus_t bus;
	shr_link_t link;
	logic [7:0] rdata, d;
	logic pbn, pboe, pcn, pcoe, core_reset, ext_rst, ext_nr, osm, eep;
	logic [2:0] msg, phy, hold_off;
	logic [1:0] pin, mf;
	logic [1:0][7:0] ml, rl;
	logic saw_core, saw_ext;
	logic [2:0] saw_phy;
	logic [7:0] nc [3] = '{8'h00, 8'h04, 8'h03};
	int err_total, total_checks, cycles;

	shr_top shr_top_inst (.core_clk(core_clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
		.link(link), .bridge_reset_in_n(bridge_reset_in_n), .port_b_reset_out_n(pbn),
		.port_b_reset_oe(pboe), .port_c_reset_out_n(pcn), .port_c_reset_oe(pcoe),
		.hot_reset_msg(msg), .core_reset(core_reset), .port_phy_reset(phy),
		.ext_side_reset(ext_rst), .hold_off(hold_off), .ext_side_not_ready(ext_nr),
		.opposite_side_mode(osm), .eeprom_reload(eep));
	shr_link_model shr_link_model_inst (.core_clk(core_clk), .out_n({pcn, pbn}),
		.oe({pcoe, pboe}), .msg(msg[2:1]), .pin(pin), .msg_len(ml), .rst_len(rl),
		.msg_first(mf));

	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e)
		begin
			$display("unexpected %s expected %h seen %h", n, e, g);
			err_total++;
		end
	endtask

	// a gap cycle after each strobe keeps one assignment per time step
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		bus <= '0;
		@(posedge core_clk);
	endtask

	task automatic rc(input logic [3:0] a, input logic [7:0] e, input string n);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		bus <= '0;
		#1 d = rdata;
		@(posedge core_clk);
		chk(n, e, d);
	endtask

	task automatic settle;
		saw_core = 1'b0;
		saw_ext = 1'b0;
		saw_phy = 3'h0;
		for (int n = 0; n < 80 && !(n > 14 && hold_off === 3'b000 && core_reset === 1'b0); n++)
		begin
			@(posedge core_clk);
			#1 saw_core |= core_reset;
			saw_ext |= ext_rst;
			saw_phy |= phy;
		end
		chk("idle", 8'h00, {5'h00, hold_off});
	endtask

	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			err_total++;
			end_of_test();
		end
	end

	initial
	begin
		rst_b = 1'b0;
		bus = '0;
		link = '0;
		bridge_reset_in_n = 1'b1;
		repeat (3) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		rc(OFS_CTRL, CTRL_RESET, "ctrl");
		rc(OFS_NTB_CTRL, 8'h10, "bridge ctrl");
		rc(4'h2, BUS_UNMAPPED, "unmapped");
		wr(OFS_GPIO_MODE, 8'h03);
		wr(OFS_CTRL, 8'h02);
		settle();
		chk("b msg", 8'(MSG_CYCLES), ml[0]);
		chk("b pulse", 8'(RST_OUT_CYCLES), rl[0]);
		chk("b order", 8'h01, {7'h00, mf[0]});
		chk("b phy", 8'h02, {5'h00, saw_phy});
		chk("local core", 8'h00, {7'h00, saw_core});
		chk("pins idle", 8'h03, {6'h00, pin});
		chk("opposite_side_mode", 8'h01, {7'h00, osm});
		wr(OFS_CTRL, 8'h01);
		settle();
		chk("c msg", 8'(MSG_CYCLES), ml[1]);
		chk("c pulse", 8'(RST_OUT_CYCLES), rl[1]);
		chk("order", 8'h03, {6'h00, mf});
		chk("ds phy", 8'h06, {5'h00, saw_phy});
		chk("ds core", 8'h00, {7'h00, saw_core});
		rc(OFS_GPIO_MODE, 8'h03, "gpio kept");
		for (int i = 0; i < 3; i++)
		begin
			link <= shr_link_t'(3'b100 >> i);
			@(posedge core_clk);
			link <= '0;
			settle();
			chk("global core", {7'h00, i < 2}, {7'h00, saw_core});
			chk("global phy", (i < 2) ? 8'h07 : 8'h00, {5'h00, saw_phy});
			chk("eeprom", 8'h00, {7'h00, eep});
		end
		chk("oe", 8'h00, {6'h00, pcoe, pboe});
		chk("pins off", 8'h00, {6'h00, pin});
		rc(OFS_GPIO_MODE, 8'h00, "gpio");
		wr(OFS_GPIO_MODE, 8'h02);
		wr(OFS_CTRL, 8'h18);
		for (int j = 0; j < 3; j++)
		begin
			wr(OFS_NTB_CTRL, nc[j]);
			bridge_reset_in_n <= 1'b0;
			settle();
			bridge_reset_in_n <= 1'b1;
			rc(OFS_NTB_STATUS, 8'h03, "status");
			wr(OFS_NTB_STATUS, 8'h03);
			chk("ext pulse", {7'h00, j != 1}, {7'h00, saw_ext});
			chk("prop core", {7'h00, j == 1}, {7'h00, saw_core});
			chk("not ready", {7'h00, j == 2}, {7'h00, ext_nr});
			chk("bridge opposite_side_mode", 8'h00, {7'h00, osm});
			chk("c ext", 8'(RST_OUT_CYCLES), rl[1]);
		end
		rst_b <= 1'b0;
		@(posedge core_clk);
		rst_b <= 1'b1;
		settle();
		chk("reset opposite_side_mode", 8'h01, {7'h00, osm});
		chk("reset not ready", 8'h01, {7'h00, ext_nr});
		rc(OFS_NTB_CTRL, 8'h10, "reset bridge ctrl");
		rc(OFS_CTRL, CTRL_RESET, "reset ctrl");
		end_of_test();
	end
endmodule
`default_nettype wire
